/* File: stp_defines.svh */
// constants and register map of the stepper output stage
// Overview of operation
// RULE1 - after a latched sensor event, step on for an 8-bit count, reset zero
// RULE2 - one overdrive count for sensor a events, another for sensor b
// RULE3 - counts do nothing while interrupt-driven motion control is disabled
// RULE4 - direction stays unchanged while overdrive steps run
// RULE5 - a count of zero means no extra steps for that sensor
// RULE6 - format 00 wave, 01 two-phase, 10 or 11 half-step
// RULE7 - function bit set drives phases, cleared gives plain outputs
// RULE8 - plain output mode drives pins from low four register bits
// RULE9 - motor mode: low bits read stop levels, writes to them ignored
// RULE10 - drive format changes apply at once, even while running
// RULE11 - clockwise stop: 00 low, 01 hold last phase, 1x high
// RULE12 - counterclockwise stop uses its own field with the same encoding
// RULE13 - nonzero time-out counts while stopped, then forces outputs low
// RULE14 - time-out restarts from full value each time the motor starts
// RULE15 - time-out codes 1..7 give 12,28,60,124,252,508,1020 ms
// RULE16 - stopped, all-high state, no time-out: outputs stay high forever
// RULE17 - stop state and time-out writes apply at once
// RULE18 - stop event: overdrive steps first, then ramp down and stop
// RULE19 - reverse event: overdrive in current direction, pause, then reverse
// RULE20 - time-out counts a millisecond tick divided from the core clock
`ifndef STP_DEFINES_SVH
`define STP_DEFINES_SVH

`define STP_ADDR_OVD_A      8'h09
`define STP_ADDR_OVD_B      8'h0A
`define STP_ADDR_OUT_CFG    8'h0B
`define STP_ADDR_STOP_TO    8'h0C

`define STP_RST_OVD         8'h00
`define STP_RST_OUT_CFG     8'h10
`define STP_RST_STOP_TO     8'h00

`define STP_FMT_MSB         7
`define STP_FMT_LSB         6
`define STP_FUNC_BIT        4
`define STP_TO_MSB          7
`define STP_TO_LSB          5
`define STP_TO_RSVD_BIT     4
`define STP_CCW_MSB         3
`define STP_CCW_LSB         2
`define STP_CW_MSB          1
`define STP_CW_LSB          0

`define STP_CLK_PERIOD_NS   8
`define STP_MS_NS           1000000
`define STP_MS_CYCLES       (`STP_MS_NS / `STP_CLK_PERIOD_NS)

`define STP_TO_MS_1         10'h00C
`define STP_TO_MS_2         10'h01C
`define STP_TO_MS_3         10'h03C
`define STP_TO_MS_4         10'h07C
`define STP_TO_MS_5         10'h0FC
`define STP_TO_MS_6         10'h1FC
`define STP_TO_MS_7         10'h3FC

`endif

/* File: stp_pkg.sv */
// types shared by the stepper output stage
package stp_pkg;

    typedef enum logic [1:0] {
        STP_FMT_WAVE,
        STP_FMT_TWO,
        STP_FMT_HALF,
        STP_FMT_HALF_ALT
    } stp_format_t;

    typedef enum logic [1:0] {
        STP_STOP_LOW,
        STP_STOP_HOLD,
        STP_STOP_HIGH,
        STP_STOP_HIGH_ALT
    } stp_stop_state_t;

    typedef enum {
        STP_OVD_IDLE,
        STP_OVD_STEP
    } stp_ovd_state_t;

endpackage : stp_pkg

/* File: stp_stop_timer.sv */
// stop time-out timer counting whole milliseconds while the motor rests
`timescale 1ns/1ns
`include "stp_defines.svh"

module stp_stop_timer #(
    parameter int MS_CYCLES = `STP_MS_CYCLES
) (
    input  wire logic       core_clk_in,
    input  wire logic       reset_in,
    input  wire logic       running_in,
    input  wire logic [2:0] timeout_sel_in,
    output logic            expired_out
);

    logic [16:0] div_count;
    logic [9:0]  elapsed_ms;
    logic [9:0]  period_ms;
    logic        ms_tick;
    logic        at_max;

    assign ms_tick = (div_count == 17'(MS_CYCLES - 1));                 // [RULE20]
    assign at_max  = (elapsed_ms == 10'h3FF);

    always_comb begin
        unique case (timeout_sel_in)                                    // [RULE15]
            3'h1:    period_ms = `STP_TO_MS_1;
            3'h2:    period_ms = `STP_TO_MS_2;
            3'h3:    period_ms = `STP_TO_MS_3;
            3'h4:    period_ms = `STP_TO_MS_4;
            3'h5:    period_ms = `STP_TO_MS_5;
            3'h6:    period_ms = `STP_TO_MS_6;
            3'h7:    period_ms = `STP_TO_MS_7;
            default: period_ms = 10'h000;
        endcase
    end

    // compared live so a new setting takes effect at once
    assign expired_out = !running_in && (timeout_sel_in != 3'h0)
                         && (elapsed_ms >= period_ms);                  // [RULE13] [RULE17]

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_count <= 17'h00000;
        end else if (running_in || ms_tick) begin
            div_count <= 17'h00000;
        end else begin
            div_count <= div_count + 17'h00001;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            elapsed_ms <= 10'h000;
        end else if (running_in) begin
            elapsed_ms <= 10'h000;                                      // [RULE14]
        end else if (ms_tick && !at_max) begin
            elapsed_ms <= elapsed_ms + 10'h001;                         // [RULE13]
        end
    end

endmodule : stp_stop_timer

/* File: stp_output_stage.sv */
// stepper output stage: overdrive, phase sequencer, stop state, registers
`timescale 1ns/1ns
`include "stp_defines.svh"

module stp_output_stage #(
    parameter int MS_CYCLES = `STP_MS_CYCLES
) (
    input  wire logic       core_clk_in,
    input  wire logic       reset_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       int_ctrl_enable_in,
    input  wire logic       sensor_a_event_in,
    input  wire logic       sensor_b_event_in,
    input  wire logic       action_reverse_in,
    input  wire logic       motor_running_in,
    input  wire logic       direction_ccw_in,
    input  wire logic       step_tick_in,
    output logic      [3:0] coil_out,
    output logic            overdrive_busy_out,
    output logic            hold_direction_ccw_out,
    output logic            stop_req_out,
    output logic            reverse_req_out
);

    // registers
    logic [7:0] overdrive_count_sensor_a;
    logic [7:0] overdrive_count_sensor_b;
    logic [7:0] output_function_and_phase;
    logic [7:0] stop_state_and_timeout;

    // sequencer and stop bookkeeping
    logic [2:0] phase_pos;
    logic [3:0] stop_levels;
    logic       last_dir_ccw;
    logic [7:0] ovd_left;
    logic       ovd_reverse;
    stp_pkg::stp_ovd_state_t ovd_state;
    stp_pkg::stp_ovd_state_t next_ovd_state;

    // decode
    wire wr_ovd_a   = reg_wr_in && (reg_addr_in == `STP_ADDR_OVD_A);
    wire wr_ovd_b   = reg_wr_in && (reg_addr_in == `STP_ADDR_OVD_B);
    wire wr_out_cfg = reg_wr_in && (reg_addr_in == `STP_ADDR_OUT_CFG);
    wire wr_stop_to = reg_wr_in && (reg_addr_in == `STP_ADDR_STOP_TO);

    wire motor_mode = output_function_and_phase[`STP_FUNC_BIT];        // [RULE7]
    wire stp_pkg::stp_format_t drive_fmt = stp_pkg::stp_format_t'(
        output_function_and_phase[`STP_FMT_MSB:`STP_FMT_LSB]);
    wire half_step  = (drive_fmt == stp_pkg::STP_FMT_HALF) ||
                      (drive_fmt == stp_pkg::STP_FMT_HALF_ALT);         // [RULE6]
    wire [2:0] to_sel =
        stop_state_and_timeout[`STP_TO_MSB:`STP_TO_LSB];
    wire stp_pkg::stp_stop_state_t cw_stop = stp_pkg::stp_stop_state_t'(
        stop_state_and_timeout[`STP_CW_MSB:`STP_CW_LSB]);
    wire stp_pkg::stp_stop_state_t ccw_stop = stp_pkg::stp_stop_state_t'(
        stop_state_and_timeout[`STP_CCW_MSB:`STP_CCW_LSB]);

    // overdrive event capture
    wire any_event  = sensor_a_event_in || sensor_b_event_in;
    wire ovd_accept = (ovd_state == stp_pkg::STP_OVD_IDLE) && any_event
                      && int_ctrl_enable_in && motor_running_in;        // [RULE3]
    wire [7:0] ovd_load = sensor_a_event_in ? overdrive_count_sensor_a
                                            : overdrive_count_sensor_b; // [RULE2]
    wire ovd_skip   = ovd_accept && (ovd_load == 8'h00);                // [RULE5]
    wire ovd_last   = (ovd_state == stp_pkg::STP_OVD_STEP) && step_tick_in
                      && (ovd_left == 8'h01);                           // [RULE1]
    wire ovd_finish = ovd_skip || ovd_last;
    wire fin_rev    = ovd_skip ? action_reverse_in : ovd_reverse;

    // direction used by the sequencer is frozen during overdrive
    wire dir_ccw = (ovd_state == stp_pkg::STP_OVD_STEP) ? last_dir_ccw
                                                        : direction_ccw_in; // [RULE4]

    // phase pattern: half-step table, even entries one coil, odd entries two
    wire [2:0] pat_index = half_step ? phase_pos :
        {phase_pos[2:1], (drive_fmt == stp_pkg::STP_FMT_TWO)};          // [RULE6] [RULE10]
    logic [3:0] phase_pattern;
    always_comb begin
        unique case (pat_index)
            3'h0: phase_pattern = 4'h1;
            3'h1: phase_pattern = 4'h3;
            3'h2: phase_pattern = 4'h2;
            3'h3: phase_pattern = 4'h6;
            3'h4: phase_pattern = 4'h4;
            3'h5: phase_pattern = 4'hC;
            3'h6: phase_pattern = 4'h8;
            3'h7: phase_pattern = 4'h9;
        endcase
    end

    wire [2:0] pos_stride = half_step ? 3'h1 : 3'h2;
    wire [2:0] next_pos   = dir_ccw ? (phase_pos - pos_stride)
                                    : (phase_pos + pos_stride);

    // stop-time output selection
    wire timed_out;
    wire stp_pkg::stp_stop_state_t stop_sel = last_dir_ccw ? ccw_stop
                                                           : cw_stop;   // [RULE12]
    logic [3:0] stop_pattern;
    always_comb begin
        unique case (stop_sel)                                          // [RULE11]
            stp_pkg::STP_STOP_LOW:  stop_pattern = 4'h0;
            stp_pkg::STP_STOP_HOLD: stop_pattern = phase_pattern;
            default:                stop_pattern = 4'hF;                // [RULE16]
        endcase
    end

    wire [3:0] next_coil =
        !motor_mode      ? output_function_and_phase[3:0] :             // [RULE8]
        motor_running_in ? phase_pattern :
        timed_out        ? 4'h0 :                                       // [RULE13]
                           stop_pattern;                                // [RULE17]

    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr_in)
            `STP_ADDR_OVD_A:   rd_mux = overdrive_count_sensor_a;
            `STP_ADDR_OVD_B:   rd_mux = overdrive_count_sensor_b;
            `STP_ADDR_OUT_CFG: rd_mux = {output_function_and_phase[7:4],
                motor_mode ? stop_levels
                           : output_function_and_phase[3:0]};           // [RULE9]
            `STP_ADDR_STOP_TO: rd_mux = stop_state_and_timeout;
            default:           rd_mux = 8'h00;
        endcase
    end

    stp_stop_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_stop_timer (
        .core_clk_in    (core_clk_in),
        .reset_in       (reset_in),
        .running_in     (motor_running_in),
        .timeout_sel_in (to_sel),
        .expired_out    (timed_out)
    );

    // register writes
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            overdrive_count_sensor_a <= `STP_RST_OVD;                   // [RULE1]
            overdrive_count_sensor_b <= `STP_RST_OVD;
        end else begin
            if (wr_ovd_a) begin
                overdrive_count_sensor_a <= reg_wdata_in;               // [RULE2]
            end
            if (wr_ovd_b) begin
                overdrive_count_sensor_b <= reg_wdata_in;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            output_function_and_phase <= `STP_RST_OUT_CFG;              // [RULE7]
        end else if (wr_out_cfg) begin
            output_function_and_phase[7:6] <= reg_wdata_in[7:6];        // [RULE10]
            output_function_and_phase[4]   <= reg_wdata_in[4];
            if (!motor_mode) begin
                output_function_and_phase[3:0] <= reg_wdata_in[3:0];    // [RULE9]
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            stop_state_and_timeout <= `STP_RST_STOP_TO;
        end else if (wr_stop_to) begin
            stop_state_and_timeout <= reg_wdata_in;                     // [RULE17]
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end
    end

    // sequencer, direction memory, stop levels
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            phase_pos <= 3'h0;
        end else if (motor_running_in && step_tick_in) begin
            phase_pos <= next_pos;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            last_dir_ccw <= 1'b0;
        end else if (motor_running_in
                     && (ovd_state == stp_pkg::STP_OVD_IDLE)) begin
            last_dir_ccw <= direction_ccw_in;                           // [RULE4]
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            stop_levels <= 4'h0;
        end else if (!motor_running_in) begin
            stop_levels <= coil_out;                                    // [RULE9]
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            coil_out <= 4'h0;
        end else begin
            coil_out <= next_coil;
        end
    end

    // overdrive state machine
    always_comb begin
        next_ovd_state = ovd_state;
        unique case (ovd_state)
            stp_pkg::STP_OVD_IDLE: begin
                if (ovd_accept && !ovd_skip) begin
                    next_ovd_state = stp_pkg::STP_OVD_STEP;
                end
            end
            stp_pkg::STP_OVD_STEP: begin
                if (ovd_last || !motor_running_in) begin
                    next_ovd_state = stp_pkg::STP_OVD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ovd_state <= stp_pkg::STP_OVD_IDLE;
        end else begin
            ovd_state <= next_ovd_state;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ovd_left    <= 8'h00;
            ovd_reverse <= 1'b0;
        end else if (ovd_accept) begin
            ovd_left    <= ovd_load;                                    // [RULE1]
            ovd_reverse <= action_reverse_in;
        end else if ((ovd_state == stp_pkg::STP_OVD_STEP) && step_tick_in) begin
            ovd_left    <= ovd_left - 8'h01;
        end
    end

    // follow-on request once the extra steps are done
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            stop_req_out    <= 1'b0;
            reverse_req_out <= 1'b0;
        end else begin
            stop_req_out    <= ovd_finish && !fin_rev;                  // [RULE18]
            reverse_req_out <= ovd_finish && fin_rev;                   // [RULE19]
        end
    end

    assign overdrive_busy_out     = (ovd_state == stp_pkg::STP_OVD_STEP); // [RULE4]
    assign hold_direction_ccw_out = last_dir_ccw;

endmodule : stp_output_stage

/* File: stp_coil_driver_model.sv */
// behavioural model of the external coil driver stage
`timescale 1ns/1ns
module stp_coil_driver_model (
    input  wire logic [3:0] coil_in,
    output logic      [3:0] drive_out
);
    // each driver follows its logic input after a short delay
    assign #2 drive_out = coil_in;
endmodule : stp_coil_driver_model

/* File: stp_output_stage_monitor.sv */
// port checker for the stepper output stage
`timescale 1ns/1ns
module stp_output_stage_monitor #(
    parameter int MS_CYCLES = 4
) (
    input wire logic       core_clk_in,
    input wire logic       reset_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       int_ctrl_enable_in,
    input wire logic       sensor_a_event_in,
    input wire logic       sensor_b_event_in,
    input wire logic       action_reverse_in,
    input wire logic       motor_running_in,
    input wire logic       direction_ccw_in,
    input wire logic       step_tick_in,
    input wire logic [3:0] coil_out,
    input wire logic       overdrive_busy_out,
    input wire logic       hold_direction_ccw_out,
    input wire logic       stop_req_out,
    input wire logic       reverse_req_out
);
    logic [7:0] cfg, st, ova, ovb, ovn;
    logic [8:0] tcnt;
    int         stc;
    int         tmo;
    wire        ev = sensor_a_event_in | sensor_b_event_in;
    wire        take = ev & int_ctrl_enable_in & motor_running_in
                       & ~overdrive_busy_out;
    wire  [7:0] ovsel = sensor_a_event_in ? ova : ovb;
    wire  [1:0] fld = hold_direction_ccw_out ? st[3:2] : st[1:0];
    wire  [3:0] rot = direction_ccw_in ? {coil_out[0], coil_out[3:1]}
                                       : {coil_out[2:0], coil_out[3]};
    wire        req = stop_req_out | reverse_req_out;
    assign tmo = ((1 << (st[7:5] + 3)) - 4) * MS_CYCLES;
    // register mirrors
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cfg <= 8'h10;
            st  <= 8'h00;
            ova <= 8'h00;
            ovb <= 8'h00;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                8'h09: ova <= reg_wdata_in;
                8'h0A: ovb <= reg_wdata_in;
                8'h0B: cfg <= {reg_wdata_in[7:4] & 4'hD,
                    cfg[4] ? cfg[3:0] : reg_wdata_in[3:0]};
                8'h0C: st <= reg_wdata_in;
                default: ;
            endcase
        end
    end
    // tick and stop counts
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tcnt <= 9'h000;
            ovn  <= 8'h00;
            stc  <= 0;
        end else begin
            if (take) begin
                tcnt <= 9'h000;
                ovn  <= ovsel;
            end else if (step_tick_in && overdrive_busy_out) begin
                tcnt <= tcnt + 9'h001;
            end
            stc <= motor_running_in ? 0 : stc + (stc < 1100000 ? 1 : 0);
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    a_ovd_off: assert property (
        ev && !int_ctrl_enable_in && !overdrive_busy_out
        |=> !overdrive_busy_out && !req) else $error("event acted on");
    a_ovd_zero: assert property (
        take && ovsel == 8'h00 |=> !overdrive_busy_out
        && reverse_req_out == $past(action_reverse_in)
        && stop_req_out != $past(action_reverse_in))
        else $error("zero count wrong");
    a_ovd_start: assert property (
        take && ovsel != 8'h00 |=> overdrive_busy_out && !req)
        else $error("extra steps not started");
    a_ovd_done: assert property (
        $fell(overdrive_busy_out) && motor_running_in
        && $past(motor_running_in) |-> tcnt == {1'b0, ovn} && req)
        else $error("extra step count wrong");
    a_req_cause: assert property (
        req |-> $past(take) || $fell(overdrive_busy_out))
        else $error("request without cause");
    a_dir_hold: assert property (
        overdrive_busy_out && $past(overdrive_busy_out)
        |-> $stable(hold_direction_ccw_out)) else $error("direction moved");
    a_gpo_level: assert property (
        !cfg[4] && $stable(cfg) |-> coil_out == cfg[3:0])
        else $error("plain output level wrong");
    a_stop_level: assert property (
        cfg[4] && $stable(cfg) && $stable(st) && st[7:5] == 3'h0
        && !motor_running_in && !$past(motor_running_in)
        && $stable(hold_direction_ccw_out) && fld != 2'h1
        |-> coil_out == {4{fld[1]}}) else $error("stop level wrong");
    a_to_early: assert property (
        cfg[4] && $stable(st) && fld == 2'h2 && st[7:5] != 3'h0
        && stc > 3 && stc < tmo - MS_CYCLES |-> coil_out == 4'hF)
        else $error("time-out too early");
    a_to_late: assert property (
        cfg[4] && $stable(st) && st[7:5] != 3'h0
        && stc > tmo + MS_CYCLES + 3 |-> coil_out == 4'h0)
        else $error("time-out too late");
    a_wave_step: assert property (
        step_tick_in && motor_running_in && $past(motor_running_in)
        && cfg[7:4] == 4'h1 && !overdrive_busy_out && $stable(cfg)
        && direction_ccw_in == hold_direction_ccw_out
        && coil_out inside {4'h1, 4'h2, 4'h4, 4'h8}
        |-> ##2 coil_out == $past(rot, 2)) else $error("wave step wrong");
endmodule : stp_output_stage_monitor

bind stp_output_stage stp_output_stage_monitor #(
    .MS_CYCLES(MS_CYCLES)
) u_mon (
    .core_clk_in, .reset_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
    .reg_wdata_in, .reg_rdata_out, .int_ctrl_enable_in,
    .sensor_a_event_in, .sensor_b_event_in, .action_reverse_in,
    .motor_running_in, .direction_ccw_in, .step_tick_in, .coil_out,
    .overdrive_busy_out, .hold_direction_ccw_out, .stop_req_out,
    .reverse_req_out
);

/* File: tb.sv */
// self-checking testbench for the stepper output stage
`timescale 1ns/1ns
module tb;
    localparam int MS = 4;
    logic       core_clk_in, reset_in, reg_wr_in, reg_rd_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic       int_ctrl_enable_in, sensor_a_event_in, sensor_b_event_in;
    logic       action_reverse_in, motor_running_in, direction_ccw_in;
    logic       step_tick_in, overdrive_busy_out, hold_direction_ccw_out;
    logic       stop_req_out, reverse_req_out;
    logic [3:0] coil_out, drv_out;
    int         bad_count, num_checks;
    logic [3:0] ht [8] = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8, 4'h9};

    stp_output_stage #(.MS_CYCLES(MS)) dut (
        .core_clk_in, .reset_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
        .reg_wdata_in, .reg_rdata_out, .int_ctrl_enable_in,
        .sensor_a_event_in, .sensor_b_event_in, .action_reverse_in,
        .motor_running_in, .direction_ccw_in, .step_tick_in, .coil_out,
        .overdrive_busy_out, .hold_direction_ccw_out, .stop_req_out,
        .reverse_req_out
    );
    stp_coil_driver_model u_drv (.coil_in(coil_out), .drive_out(drv_out));

    always #4 core_clk_in = ~core_clk_in;

    task automatic wrap_up;
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [7:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rc(input logic [7:0] a, exp);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        cyc(1);
        chk("rdata", reg_rdata_out, exp);
    endtask : rc

    task automatic tick(input int w = 1);
        @(posedge core_clk_in);
        step_tick_in <= 1'b1;
        @(posedge core_clk_in);
        step_tick_in <= 1'b0;
        cyc(w);
    endtask : tick

    task automatic run(input logic r, d);
        @(posedge core_clk_in);
        motor_running_in <= r;
        direction_ccw_in <= d;
    endtask : run

    function automatic int idx(input logic [3:0] p);
        for (int j = 0; j < 8; j++)
            if (ht[j] === p) return j;
        return 8;
    endfunction : idx

    task automatic t_regs;
        rc(8'h09, 8'h00);
        rc(8'h0A, 8'h00);
        rc(8'h0B, 8'h10);
        rc(8'h0C, 8'h00);
        wr(8'h09, 8'h5A);
        wr(8'h0A, 8'hA5);
        wr(8'h0D, 8'h77);
        wr(8'h0B, 8'hFF);
        rc(8'h09, 8'h5A);
        rc(8'h0A, 8'hA5);
        rc(8'h0D, 8'h00);
        rc(8'h0B, 8'hD0);
        wr(8'h0B, 8'h00);
        for (int v = 1; v < 16; v += 5) begin
            wr(8'h0B, v[7:0]);
            cyc(2);
            chk("coil", coil_out, v[7:0]);
            rc(8'h0B, v[7:0]);
        end
        wr(8'h0B, 8'h10);
    endtask : t_regs

    task automatic t_seq;
        int i;
        for (int f = 0; f < 4; f++) begin
            for (int d = 0; d < 2; d++) begin
                wr(8'h0B, {f[1:0], 6'h10});
                run(1'b1, d[0]);
                tick;
                for (int k = 0; k < 5; k++) begin
                    i = idx(coil_out);
                    chk("shape", (i < 8 && (f > 1 || i % 2 == f)), 8'h01);
                    tick;
                    chk("phase", coil_out, ht[(i + (f > 1 ? 1 : 2) * (d ? 7 : 1)) % 8]);
                end
            end
        end
    endtask : t_seq

    task automatic t_stop;
        logic [3:0] last;
        logic [3:0] e;
        for (int d = 0; d < 2; d++) begin
            wr(8'h0B, 8'h10);
            run(1'b1, d[0]);
            tick;
            tick;
            last = coil_out;
            run(1'b0, d[0]);
            for (int v = 0; v < 4; v++) begin
                wr(8'h0C, d ? {4'h0, v[1:0], 2'h3} : {4'h0, 2'h3, v[1:0]});
                cyc(2);
                e = v == 0 ? 4'h0 : (v == 1 ? last : 4'hF);
                chk("coil", coil_out, e);
                rc(8'h0B, {4'h1, e});
            end
        end
    endtask : t_stop

    task automatic t_to;
        int ms;
        for (int s = 1; s < 8; s++) begin
            ms = (1 << (s + 3)) - 4;
            run(1'b1, 1'b0);
            tick;
            wr(8'h0C, {s[2:0], 5'h02});
            run(1'b0, 1'b0);
            cyc((ms - 1) * MS - 4);
            chk("coil", coil_out, 8'h0F);
            cyc(3 * MS + 6);
            chk("coil", coil_out, 8'h00);
        end
        wr(8'h0C, 8'h02);
        cyc(2);
        chk("coil", coil_out, 8'h0F);
        cyc(1100 * MS);
        chk("coil", coil_out, 8'h0F);
        chk("drive", drv_out, 8'h0F);
    endtask : t_to

    task automatic t_ovd(input logic sb, rv, en, input logic [7:0] n);
        @(posedge core_clk_in);
        int_ctrl_enable_in <= en;
        action_reverse_in  <= rv;
        motor_running_in   <= 1'b1;
        sensor_a_event_in  <= !sb;
        sensor_b_event_in  <= sb;
        @(posedge core_clk_in);
        sensor_a_event_in <= 1'b0;
        sensor_b_event_in <= 1'b0;
        #1;
        chk("busy", overdrive_busy_out, en && n != 0);
        chk("stop", stop_req_out, en && n == 0 && !rv);
        chk("rev", reverse_req_out, en && n == 0 && rv);
        if (en && n != 0) begin
            run(1'b1, !direction_ccw_in);
            cyc(2);
            chk("dir", hold_direction_ccw_out, !direction_ccw_in);
            repeat (n - 1) tick;
            chk("busy", overdrive_busy_out, 8'h01);
            tick(0);
            chk("busy", overdrive_busy_out, 8'h00);
            chk("stop", stop_req_out, !rv);
            chk("rev", reverse_req_out, rv);
        end
    endtask : t_ovd

    initial begin
        core_clk_in = 1'b0;
        reset_in = 1'b1;
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        {int_ctrl_enable_in, sensor_a_event_in, sensor_b_event_in} = '0;
        {action_reverse_in, motor_running_in, direction_ccw_in} = '0;
        step_tick_in = 1'b0;
        bad_count = 0;
        num_checks = 0;
        repeat (12) @(posedge core_clk_in);
        reset_in <= 1'b0;
        t_regs;
        t_seq;
        t_stop;
        t_to;
        wr(8'h09, 8'h03);
        wr(8'h0A, 8'h00);
        t_ovd(1'b0, 1'b0, 1'b0, 8'h03);
        t_ovd(1'b1, 1'b1, 1'b1, 8'h00);
        t_ovd(1'b0, 1'b1, 1'b1, 8'h03);
        wr(8'h09, 8'h00);
        wr(8'h0A, 8'h01);
        t_ovd(1'b1, 1'b0, 1'b1, 8'h01);
        t_ovd(1'b0, 1'b0, 1'b1, 8'h00);
        wrap_up;
    end

    initial begin
        repeat (100000) @(posedge core_clk_in);
        bad_count++;
        wrap_up;
    end
endmodule : tb
